// ===== hw/warmup_core.sv
// Purpose: 16-bit chained up-counter with upper-byte match
// Assumes: tick is a one-cycle pulse of the selected source clock
// Notes: Lower byte of the period is never compared
`timescale 1ns/100ps
module warmup_core (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Control
    input wire logic tick,
    input wire logic run,
    input wire logic [7:0] period_high_byte,
    // Status
    output logic [15:0] count_q,
    output logic match_q
);
    logic [15:0] next_cnt;

    assign next_cnt = count_q + 16'h0001;

    // ------------------------------------------------------------------
    // Counter: two bytes form one 16-bit up-counter
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= 16'h0000;
        end else if (run && tick) begin
            // Looking at the incremented value makes 0100H give exactly 256 ticks
            if (next_cnt[15:8] == period_high_byte) begin
                count_q <= 16'h0000;
            end else begin
                count_q <= next_cnt;
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            match_q <= 1'b0;
        end else begin
            match_q <= run && tick && (next_cnt[15:8] == period_high_byte);
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_hold_stopped: assert property (@(posedge core_clk) disable iff (!arst_n)
        !$past(run) |-> count_q == $past(count_q))
        else $error("counter moved while stopped");
    a_match_clears: assert property (@(posedge core_clk) disable iff (!arst_n)
        match_q |-> count_q == 16'h0000)
        else $error("match did not clear counter");
    a_match_pulse: assert property (@(posedge core_clk) disable iff (!arst_n)
        match_q |=> !match_q || $past(tick))
        else $error("match held without a tick");
    a_upper_only: assert property (@(posedge core_clk) disable iff (!arst_n)
        match_q |-> $past(next_cnt[15:8]) == $past(period_high_byte))
        else $error("match without upper byte equal");
    a_count_step: assert property (@(posedge core_clk) disable iff (!arst_n)
        $past(run) && $past(tick) && !match_q |-> count_q == $past(count_q) + 16'h0001)
        else $error("counter did not step by one");
    c_match: cover property (@(posedge core_clk) disable iff (!arst_n) match_q);
endmodule

// ===== hw/warmup_counter.sv
// Purpose: Oscillator warm-up counter with Avalon-MM registers and interrupt
// Assumes: slow_tick and fast_tick are synchronous one-cycle source pulses
// Notes: Every request sees one wait cycle; unmapped reads return zero
`timescale 1ns/100ps
module warmup_counter
    import warmup_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Avalon-MM slave
    input warmup_pkg::avl_req_t avl_req,
    output logic [31:0] avl_readdata,
    output logic avl_waitrequest,
    // Source clock ticks
    input wire logic slow_tick,
    input wire logic fast_tick,
    // Events
    output logic warmup_match_irq,
    output logic irq
);
    logic [7:0] lower_timer_control_q;
    logic [7:0] upper_timer_control_q;
    logic [7:0] period_low_byte_q;
    logic [7:0] period_high_byte_q;
    logic irq_status_q;
    logic irq_mask_q;
    logic [31:0] rdata_d;
    logic wr_en;
    logic run;
    logic tick;
    logic [15:0] count;
    logic match;

    // ------------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------------
    // A single wait cycle gives time to register read data without a comb path
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            avl_waitrequest <= 1'b1;
        end else if ((avl_req.read || avl_req.write) && avl_waitrequest) begin
            avl_waitrequest <= 1'b0;
        end else begin
            avl_waitrequest <= 1'b1;
        end
    end

    assign wr_en = avl_req.write && !avl_waitrequest;

    always_comb begin
        rdata_d = 32'h0000_0000;
        unique case (avl_req.address)
            lower_ctrl_off: rdata_d = {24'h00_0000, lower_timer_control_q};
            upper_ctrl_off: rdata_d = {24'h00_0000, upper_timer_control_q};
            period_lo_off: rdata_d = {24'h00_0000, period_low_byte_q};
            period_hi_off: rdata_d = {24'h00_0000, period_high_byte_q};
            count_off: rdata_d = {16'h0000, count};
            irq_status_off: rdata_d = {31'h0000_0000, irq_status_q};
            irq_mask_off: rdata_d = {31'h0000_0000, irq_mask_q};
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            avl_readdata <= 32'h0000_0000;
        end else if (avl_req.read && avl_waitrequest) begin
            avl_readdata <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // Control and period registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            lower_timer_control_q <= ctrl_reset;
            upper_timer_control_q <= ctrl_reset;
            period_low_byte_q <= period_reset;
            period_high_byte_q <= period_reset;
        end else if (wr_en) begin
            unique case (avl_req.address)
                lower_ctrl_off: lower_timer_control_q <= avl_req.writedata[7:0];
                upper_ctrl_off: upper_timer_control_q <= avl_req.writedata[7:0];
                period_lo_off: period_low_byte_q <= avl_req.writedata[7:0];
                period_hi_off: period_high_byte_q <= avl_req.writedata[7:0];
                default: ;
            endcase
        end
    end

    // Counting only happens in warm-up mode with the run bit set
    assign run = upper_timer_control_q[ctrl_run_bit] &&
        (upper_timer_control_q[2:0] == mode_warmup);
    // Slow source for slow-oscillator warm-up, fast otherwise
    assign tick = (lower_timer_control_q[src_sel_lsb +: 3] == src_sel_slow) ?
        slow_tick : fast_tick;

    warmup_core u_core (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .tick(tick),
        .run(run),
        .period_high_byte(period_high_byte_q),
        .count_q(count),
        .match_q(match)
    );

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            warmup_match_irq <= 1'b0;
        end else begin
            warmup_match_irq <= match;
        end
    end

    // A match in the same cycle as a write-one clear stays set
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_status_q <= 1'b0;
        end else if (match) begin
            irq_status_q <= 1'b1;
        end else if (wr_en && avl_req.address == irq_status_off &&
                     avl_req.writedata[irq_match_bit]) begin
            irq_status_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_mask_q <= 1'b0;
        end else if (wr_en && avl_req.address == irq_mask_off) begin
            irq_mask_q <= avl_req.writedata[irq_match_bit];
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_status_q && irq_mask_q;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_irq_follows: assert property (@(posedge core_clk) disable iff (!arst_n)
        match |=> warmup_match_irq && irq_status_q)
        else $error("match did not raise interrupt");
    a_irq_single: assert property (@(posedge core_clk) disable iff (!arst_n)
        warmup_match_irq |-> $past(match))
        else $error("interrupt pulse without match");
    a_mode_gate: assert property (@(posedge core_clk) disable iff (!arst_n)
        upper_timer_control_q[2:0] != mode_warmup |=> $stable(count))
        else $error("counter ran outside warm-up mode");
    a_wait_once: assert property (@(posedge core_clk) disable iff (!arst_n)
        !avl_waitrequest |=> avl_waitrequest)
        else $error("waitrequest low two cycles");
    a_src_select: assert property (@(posedge core_clk) disable iff (!arst_n)
        run && lower_timer_control_q[src_sel_lsb +: 3] == src_sel_slow && !slow_tick
        |=> $stable(count))
        else $error("slow warm-up counted without slow tick");
    a_fast_select: assert property (@(posedge core_clk) disable iff (!arst_n)
        run && lower_timer_control_q[src_sel_lsb +: 3] != src_sel_slow && !fast_tick
        |=> $stable(count))
        else $error("fast warm-up counted without fast tick");
    a_run_gate: assert property (@(posedge core_clk) disable iff (!arst_n)
        !upper_timer_control_q[ctrl_run_bit] |=> $stable(count))
        else $error("counter moved with run bit clear");

    // ------------------------------------------------------------------
    // Register and status checks
    // ------------------------------------------------------------------
    // Software polls with no fixed wait count, so the answer must always come
    a_wait_answer: assert property (@(posedge core_clk) disable iff (!arst_n)
        (avl_req.read || avl_req.write) && avl_waitrequest |=> !avl_waitrequest)
        else $error("request not answered after one wait");
    a_read_capture: assert property (@(posedge core_clk) disable iff (!arst_n)
        avl_req.read && avl_waitrequest |=> avl_readdata == $past(rdata_d))
        else $error("read data not captured");
    a_ctrl_write: assert property (@(posedge core_clk) disable iff (!arst_n)
        wr_en && avl_req.address == upper_ctrl_off |=>
        upper_timer_control_q == $past(avl_req.writedata[7:0]))
        else $error("upper control write lost");
    a_period_write: assert property (@(posedge core_clk) disable iff (!arst_n)
        wr_en && avl_req.address == period_hi_off |=>
        period_high_byte_q == $past(avl_req.writedata[7:0]))
        else $error("period high byte write lost");
    a_status_sticky: assert property (@(posedge core_clk) disable iff (!arst_n)
        irq_status_q && !(wr_en && avl_req.address == irq_status_off &&
        avl_req.writedata[irq_match_bit]) |=> irq_status_q)
        else $error("status bit dropped without clear");
    a_status_clear: assert property (@(posedge core_clk) disable iff (!arst_n)
        wr_en && avl_req.address == irq_status_off && avl_req.writedata[irq_match_bit] &&
        !match |=> !irq_status_q)
        else $error("status bit not cleared by write one");
    a_mask_write: assert property (@(posedge core_clk) disable iff (!arst_n)
        wr_en && avl_req.address == irq_mask_off |=>
        irq_mask_q == $past(avl_req.writedata[irq_match_bit]))
        else $error("mask write lost");
    a_irq_level: assert property (@(posedge core_clk) disable iff (!arst_n)
        irq == $past(irq_status_q && irq_mask_q))
        else $error("interrupt level does not follow status and mask");
    c_slow_match: cover property (@(posedge core_clk) disable iff (!arst_n)
        match && lower_timer_control_q[src_sel_lsb +: 3] == src_sel_slow);
    c_fast_match: cover property (@(posedge core_clk) disable iff (!arst_n)
        match && lower_timer_control_q[src_sel_lsb +: 3] != src_sel_slow);
    c_irq_out: cover property (@(posedge core_clk) disable iff (!arst_n) irq);
endmodule

// ===== hw/warmup_pkg.sv
// Purpose: Shared constants and types for the oscillator warm-up counter
// Assumes: 32-bit Avalon-MM register bus, byte addresses
// Notes: One aligned word per register, narrow data in the low bits
package warmup_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [4:0] lower_ctrl_off = 5'h00;
    localparam logic [4:0] upper_ctrl_off = 5'h04;
    localparam logic [4:0] period_lo_off = 5'h08;
    localparam logic [4:0] period_hi_off = 5'h0c;
    localparam logic [4:0] count_off = 5'h10;
    localparam logic [4:0] irq_status_off = 5'h14;
    localparam logic [4:0] irq_mask_off = 5'h18;
    // ------------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------------
    localparam int ctrl_init_bit = 7;
    localparam int ctrl_run_bit = 3;
    localparam int src_sel_lsb = 4;
    localparam logic [2:0] src_sel_slow = 3'h4;
    localparam logic [2:0] mode_warmup = 3'h5;
    localparam logic [7:0] ctrl_reset = 8'h00;
    localparam logic [7:0] period_reset = 8'hff;
    localparam int irq_match_bit = 0;
    // ------------------------------------------------------------------
    // Bus request carrier
    // ------------------------------------------------------------------
    typedef struct packed {
        logic read;
        logic write;
        logic [4:0] address;
        logic [31:0] writedata;
    } avl_req_t;
endpackage

// ===== test/osc_source_model.sv
// Purpose: Source oscillators that feed the warm-up counter ticks
// Assumes: Ticks are one-cycle pulses of core_clk
// Notes: A disabled oscillator gives no ticks at all
`timescale 1ns/100ps
module osc_source_model #(
    parameter int slow_div = 7,
    parameter int fast_div = 1
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Oscillator enables and ticks
    input wire logic slow_en,
    input wire logic fast_en,
    output logic slow_tick,
    output logic fast_tick
);
    int slow_q;
    int fast_q;
    // Slow source ticks rarely, fast source on every cycle
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            slow_q <= 0;
            fast_q <= 0;
            slow_tick <= 1'b0;
            fast_tick <= 1'b0;
        end else begin
            slow_q <= (slow_q >= slow_div - 1) ? 0 : slow_q + 1;
            fast_q <= (fast_q >= fast_div - 1) ? 0 : fast_q + 1;
            slow_tick <= slow_en && slow_q == slow_div - 1;
            fast_tick <= fast_en && fast_q == fast_div - 1;
        end
    end
endmodule

// ===== test/warmup_counter_tb.sv
// Purpose: Self-checking bench for the warm-up counter
// Assumes: One wait cycle per bus request
// Notes: ticks_seen mirrors the counter, cleared on each match
`timescale 1ns/100ps
module warmup_counter_tb;
    import warmup_pkg::*;
    logic core_clk;
    logic arst_n;
    avl_req_t avl_req;
    logic [31:0] avl_readdata;
    logic avl_waitrequest, slow_tick, fast_tick, slow_en, fast_en;
    logic warmup_match_irq, irq, run_on, sel_slow, prev_match, prev_tick, cur_tick;
    logic [31:0] exp_q[$];
    logic [31:0] tick_q[$];
    logic [31:0] ticks_seen = 32'h0;
    int n_mismatch, cmp_count, seed;

    // A tick the counter takes while running in warm-up mode
    assign cur_tick = run_on && (sel_slow ? slow_tick : fast_tick);

    warmup_counter uut (.core_clk(core_clk), .arst_n(arst_n), .avl_req(avl_req),
        .avl_readdata(avl_readdata), .avl_waitrequest(avl_waitrequest),
        .slow_tick(slow_tick), .fast_tick(fast_tick),
        .warmup_match_irq(warmup_match_irq), .irq(irq));
    osc_source_model osc (.core_clk(core_clk), .arst_n(arst_n), .slow_en(slow_en),
        .fast_en(fast_en), .slow_tick(slow_tick), .fast_tick(fast_tick));

    // ------------------------------------------------------------------
    // Checking
    // ------------------------------------------------------------------
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge core_clk) begin
        if (avl_req.read && avl_waitrequest === 1'b0)
            check("readdata", avl_readdata, exp_q.pop_front());
        // The pulse shows two edges after the clearing tick; the tick in between
        // already belongs to the next interval
        if (warmup_match_irq === 1'b1) begin
            check("match ticks", ticks_seen - {31'h0, prev_tick}, tick_q.pop_front());
            check("match width", {31'h0, prev_match}, 32'h0);
        end
        prev_match <= warmup_match_irq;
        prev_tick <= cur_tick;
        ticks_seen <= (warmup_match_irq === 1'b1 ? {31'h0, prev_tick} : ticks_seen)
            + {31'h0, cur_tick};
    end

    // ------------------------------------------------------------------
    // Bus and warm-up sequences
    // ------------------------------------------------------------------
    task automatic bus(logic wr, logic [4:0] addr, logic [31:0] data);
        int i;
        avl_req <= '{read: !wr, write: wr, address: addr, writedata: data};
        i = 0;
        do begin
            @(posedge core_clk);
            i++;
        end while (avl_waitrequest !== 1'b0 && i < 50);
        if (i >= 50) begin
            n_mismatch++;
            stop_test();
        end
        if (wr && addr == upper_ctrl_off)
            run_on <= data[ctrl_run_bit] && data[2:0] == mode_warmup;
        avl_req <= '0;
        @(posedge core_clk);
    endtask

    task automatic rd(logic [4:0] addr, logic [31:0] exp);
        exp_q.push_back(exp);
        bus(1'b0, addr, 32'h0);
    endtask

    // Software side: enable target oscillator, run, stop, drop the old one
    task automatic warm(logic slow, logic [7:0] p);
        int i;
        if (slow) slow_en <= 1'b1;
        else fast_en <= 1'b1;
        sel_slow = slow;
        bus(1'b1, lower_ctrl_off, slow ? 32'h40 : 32'h30);
        bus(1'b1, period_lo_off, $urandom & 32'hff);
        bus(1'b1, period_hi_off, {24'h0, p});
        tick_q.push_back({16'h0, p, 8'h00});
        bus(1'b1, upper_ctrl_off, 32'h0d);
        i = 0;
        while (warmup_match_irq !== 1'b1 && i < 70000) begin
            @(posedge core_clk);
            i++;
        end
        if (i >= 70000) begin
            n_mismatch++;
            stop_test();
        end
        @(posedge core_clk);
        bus(1'b1, upper_ctrl_off, 32'h05);
        if (slow) fast_en <= 1'b0;
        else slow_en <= 1'b0;
        @(posedge core_clk);
    endtask

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    initial begin
        arst_n = 1'b0;
        avl_req = '0;
        {slow_en, fast_en, run_on, sel_slow, prev_match, prev_tick} = 6'h00;
        seed = $urandom(32'h9bb3);
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        rd(upper_ctrl_off, {24'h0, ctrl_reset});
        rd(period_hi_off, {24'h0, period_reset});
        rd(count_off, 32'h0);
        rd(5'h1c, 32'h0);
        bus(1'b1, upper_ctrl_off, 32'h05);
        rd(upper_ctrl_off, 32'h05);
        bus(1'b1, irq_mask_off, 32'h1);
        warm(1'b1, 8'h01);
        rd(irq_status_off, 32'h1);
        check("irq set", {31'h0, irq}, 32'h1);
        bus(1'b1, irq_status_off, 32'h1);
        @(posedge core_clk);
        check("irq clear", {31'h0, irq}, 32'h0);
        bus(1'b1, irq_mask_off, 32'h0);
        warm(1'b0, 8'hff);
        check("irq masked", {31'h0, irq}, 32'h0);
        bus(1'b1, irq_mask_off, 32'h1);
        @(posedge core_clk);
        check("irq unmask", {31'h0, irq}, 32'h1);
        bus(1'b1, upper_ctrl_off, 32'h0c);
        repeat (300) @(posedge core_clk);
        rd(count_off, ticks_seen);
        stop_test();
    end
endmodule
